// ===== pkg/element_defs.svh
// Constants for the protection element output logic
`ifndef ELEMENT_DEFS_SVH
`define ELEMENT_DEFS_SVH

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define MEAS_WIDTH      16
`define DELAY_WIDTH     24
`define GROUP_COUNT     6
`define GROUP_SEL_WIDTH 3

// ----------------------------------------------------------------------
// Target mode encodings
// ----------------------------------------------------------------------
`define TARGET_DISABLED 2'h0
`define TARGET_SELF_RST 2'h1
`define TARGET_LATCHED  2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DELAY_RESET     24'h000000
`define MEAS_RESET      16'h0000

`endif

// ===== pkg/element_pkg.sv
// Types shared by the protection element output logic
`include "element_defs.svh"

package element_pkg;

   typedef logic [`MEAS_WIDTH-1:0]  meas_type;
   typedef logic [`DELAY_WIDTH-1:0] delay_type;

   // One setting set of a grouped element
   typedef struct packed {
      meas_type  pickup_lo;
      meas_type  pickup_hi;
      delay_type pickup_delay;
      delay_type reset_delay;
   } setting_type;

   // Output flags of the comparator
   typedef struct packed {
      logic pickup;
      logic operate;
      logic dropout;
   } flags_type;

   // One-cycle event records
   typedef struct packed {
      logic pickup_event;
      logic dropout_event;
      logic operate_event;
   } events_type;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_PICKUP  = 2'b01,
      ST_OPERATE = 2'b10,
      ST_RESET   = 2'b11
   } op_state_type;

endpackage

// ===== hdl/protection_element.sv
// Generic protection element: comparator, timers, targets and events
//
// Overview of operation
// - Comparator flag is 1 while tested input lies inside the programmed range.
// - Pickup follows value inside setting range; operate after the set pickup delay.
// - Digital variant compares a logic state; others compare an analog value.
// - Grouped element holds six setting sets and uses the active one.
// - Control-class element ignores the active group selection.
// - Per-unit base is larger rated CT; the other input is scaled.
// - Element inactive unless function enabled; disabled after reset.
// - Operate asserts after pickup persists for the pickup delay.
// - Operate holds for the reset delay after input leaves pickup range.
// - Outputs other than trouble_led and in_service_led default to 0 and stay until run supervision is 1.
// - Run falling to 0 clears pickup, operate and dropout flags at the next clock; latched target kept.
// - Block input is one term forming run supervision.
// - Target disabled: no target message and no indicator.
// - Target self-reset: target tracks operate and clears with it.
// - Target latched: target stays set until a reset command.
// - Events disabled: no pickup, dropout or operate records.
// - Events enabled: distinct pickup, dropout and operate records.
// - Dropout event on each pickup flag fall from 1 to 0.
// - Dropout may occur while still operating when reset delay nonzero.
// - Not-programmed: trouble lit, in-service dark, contacts blocked.
// - Once programmed is stored, in-service indicator turns on.
`timescale 1ns/100ps
`include "element_defs.svh"

module protection_element #(
   parameter int MEAS_W  = `MEAS_WIDTH,
   parameter int DELAY_W = `DELAY_WIDTH,
   parameter int GROUPS  = `GROUP_COUNT
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rstn,
   // Element configuration
   input  wire logic                        function_enable,
   input  wire logic                        grouped_class,
   input  wire logic                        digital_variant,
   input  wire logic [1:0]                  target_mode,
   input  wire logic                        events_enable,
   input  wire logic [`GROUP_SEL_WIDTH-1:0] active_group,
   input  wire element_pkg::setting_type    settings [GROUPS],
   // Source scaling of second CT, ratio as Q8.8 of the larger CT
   input  wire logic                        ct2_present,
   input  wire logic [15:0]                 ct2_scale,
   // Measured inputs and supervision
   input  wire element_pkg::meas_type       meas_ct1,
   input  wire element_pkg::meas_type       meas_ct2,
   input  wire logic                        digital_in,
   input  wire logic                        block_in,
   input  wire logic                        run_extra,
   input  wire logic                        target_reset,
   // Relay state
   input  wire logic                        programmed_store,
   input  wire logic                        programmed_value,
   // Outputs
   output element_pkg::flags_type           flags,
   output element_pkg::events_type          events,
   output logic                             target_active,
   output logic                             target_led,
   output logic                             trouble_led,
   output logic                             in_service_led,
   output logic                             contacts_enable
);
   import element_pkg::*;

   // ------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------
   if (MEAS_W != `MEAS_WIDTH || DELAY_W != `DELAY_WIDTH) begin : g_width_chk
      $error("Width parameters must match the shared types");
   end
   if (GROUPS < 1 || GROUPS > `GROUP_COUNT) begin : g_group_chk
      $error("Group count out of range");
   end
   if (GROUPS >= (1 << `GROUP_SEL_WIDTH)) begin : g_sel_chk
      $error("Group selector too narrow for the group count");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic digital_meta_r;
   logic digital_sync_r;
   logic block_meta_r;
   logic block_sync_r;

   // Only the second stage feeds logic
   always_ff @(posedge clk) begin
      if (!rstn) begin
         digital_meta_r <= 1'b0;
         digital_sync_r <= 1'b0;
         // Start blocked until the pin reads low twice
         block_meta_r   <= 1'b1;
         block_sync_r   <= 1'b1;
      end else begin
         digital_meta_r <= digital_in;
         digital_sync_r <= digital_meta_r;
         block_meta_r   <= block_in;
         block_sync_r   <= block_meta_r;
      end
   end

   // ------------------------------------------------------------------
   // Relay programmed state
   // ------------------------------------------------------------------
   logic programmed_r;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         programmed_r <= 1'b0;
      end else if (programmed_store) begin
         programmed_r <= programmed_value;
      end
   end

   assign trouble_led     = ~programmed_r;
   assign in_service_led  = programmed_r;

   // ------------------------------------------------------------------
   // Setting selection and per-unit summing
   // ------------------------------------------------------------------
   function automatic meas_type sat_add(input logic [MEAS_W:0] a, input logic [MEAS_W:0] b);
      logic [MEAS_W+1:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > (MEAS_W+2)'({MEAS_W{1'b1}})) ? {MEAS_W{1'b1}} : s[MEAS_W-1:0];
   endfunction

   setting_type        active_set;
   logic [MEAS_W+15:0] ct2_product;
   meas_type           ct2_scaled;
   meas_type           meas_pu;
   logic               in_range;

   always_comb begin
      active_set = settings[0];
      if (grouped_class && active_group >= 3'h1
          && 32'(active_group) <= GROUPS) begin
         active_set = settings[active_group - 3'h1];
      end
   end

   // Q8.8 ratio: the eight fraction bits are dropped
   assign ct2_product = meas_ct2 * ct2_scale;
   assign ct2_scaled  = ct2_product[MEAS_W+7:8];
   assign meas_pu     = sat_add({1'b0, meas_ct1},
                                {1'b0, ct2_present ? ct2_scaled : `MEAS_RESET});

   always_comb begin
      if (digital_variant) begin
         in_range = digital_sync_r;
      end else begin
         in_range = (meas_pu >= active_set.pickup_lo)
                 && (meas_pu <= active_set.pickup_hi);
      end
   end

   // ------------------------------------------------------------------
   // Run supervision
   // ------------------------------------------------------------------
   logic run;

   // Any term low, block included, holds the comparator cleared
   assign run = function_enable & ~block_sync_r & run_extra;

   // ------------------------------------------------------------------
   // Pickup and operate timing
   // ------------------------------------------------------------------
   op_state_type state_r;
   delay_type    timer_r;
   logic         pickup_r;
   logic         operate_r;

   // One timer serves both delays and restarts on every state change
   always_ff @(posedge clk) begin
      if (!rstn || !run) begin
         state_r   <= ST_IDLE;
         timer_r   <= `DELAY_RESET;
         pickup_r  <= 1'b0;
         operate_r <= 1'b0;
      end else begin
         pickup_r <= in_range;
         case (state_r)
            ST_IDLE: begin
               timer_r <= `DELAY_RESET;
               if (in_range) begin
                  state_r <= ST_PICKUP;
               end
            end
            ST_PICKUP: begin
               if (!in_range) begin
                  state_r <= ST_IDLE;
                  timer_r <= `DELAY_RESET;
               end else if (timer_r >= active_set.pickup_delay) begin
                  state_r   <= ST_OPERATE;
                  operate_r <= 1'b1;
                  timer_r   <= `DELAY_RESET;
               end else begin
                  timer_r <= timer_r + 24'h000001;
               end
            end
            ST_OPERATE: begin
               timer_r <= `DELAY_RESET;
               if (!in_range) begin
                  if (active_set.reset_delay == `DELAY_RESET) begin
                     state_r   <= ST_IDLE;
                     operate_r <= 1'b0;
                  end else begin
                     state_r <= ST_RESET;
                  end
               end
            end
            // Leaving OPERATE took a cycle, so the count stops one short
            ST_RESET: begin
               if (in_range) begin
                  state_r <= ST_OPERATE;
                  timer_r <= `DELAY_RESET;
               end else if (timer_r >= active_set.reset_delay - 24'h000001) begin
                  state_r   <= ST_IDLE;
                  operate_r <= 1'b0;
                  timer_r   <= `DELAY_RESET;
               end else begin
                  timer_r <= timer_r + 24'h000001;
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               operate_r <= 1'b0;
               timer_r   <= `DELAY_RESET;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Output flags and contact blocking
   // ------------------------------------------------------------------
   logic pickup_d_r;
   logic operate_d_r;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pickup_d_r  <= 1'b0;
         operate_d_r <= 1'b0;
      end else begin
         pickup_d_r  <= pickup_r;
         operate_d_r <= operate_r;
      end
   end

   // Dropout: pickup lost while the off-delay still holds operate
   assign flags.pickup     = pickup_r;
   assign flags.operate    = operate_r;
   assign flags.dropout    = operate_r & ~pickup_r;
   assign contacts_enable  = programmed_r & operate_r;

   // ------------------------------------------------------------------
   // Event records
   // ------------------------------------------------------------------
   // A run loss clears pickup and so still reports a dropout
   always_ff @(posedge clk) begin
      if (!rstn) begin
         events <= '0;
      end else begin
         events.pickup_event  <= events_enable & pickup_r & ~pickup_d_r;
         events.dropout_event <= events_enable & ~pickup_r & pickup_d_r;
         events.operate_event <= events_enable & operate_r & ~operate_d_r;
      end
   end

   // ------------------------------------------------------------------
   // Target and indicator
   // ------------------------------------------------------------------
   logic target_latch_r;

   // Operate wins over a reset command in the same cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         target_latch_r <= 1'b0;
      end else if (target_mode != `TARGET_LATCHED) begin
         target_latch_r <= 1'b0;
      end else if (operate_r) begin
         target_latch_r <= 1'b1;
      end else if (target_reset) begin
         target_latch_r <= 1'b0;
      end
   end

   always_comb begin
      case (target_mode)
         `TARGET_SELF_RST: target_active = operate_r;
         `TARGET_LATCHED:  target_active = target_latch_r | operate_r;
         default:          target_active = 1'b0;
      endcase
   end

   assign target_led = target_active;

endmodule

// ===== verif/protection_element_assertions.sv
// Port-level checks for the protection element
`timescale 1ns/100ps
`include "element_defs.svh"
module protection_element_checker (
   // Clock, reset and controls
   input logic                   clk,
   input logic                   rstn,
   input logic                   function_enable,
   input logic [1:0]             target_mode,
   input logic                   events_enable,
   input logic                   block_in,
   input logic                   run_extra,
   input logic                   target_reset,
   input logic                   programmed_store,
   input logic                   programmed_value,
   // Observed outputs
   input element_pkg::flags_type  flags,
   input element_pkg::events_type events,
   input logic                   target_active,
   input logic                   target_led,
   input logic                   trouble_led,
   input logic                   in_service_led,
   input logic                   contacts_enable
);
   import element_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   contacts_gate_a: assert property (contacts_enable |-> in_service_led && flags.operate)
      else $error("contacts without operate");
   led_pair_a: assert property (in_service_led != trouble_led)
      else $error("status leds agree");
   store_on_a: assert property (programmed_store && programmed_value |-> ##[1:2] in_service_led)
      else $error("store ignored");
   dropout_flag_a: assert property (flags.dropout == (flags.operate && !flags.pickup))
      else $error("dropout flag wrong");
   disable_clr_a: assert property (!function_enable |=> !flags.pickup && !flags.operate)
      else $error("disabled element active");
   run_clr_a: assert property (!run_extra |=> flags == '0)
      else $error("flags kept without run");
   block_clr_a: assert property (block_in [*3] |=> flags == '0)
      else $error("flags kept under block");
   tgt_off_a: assert property (target_mode == `TARGET_DISABLED && $stable(target_mode)
      |-> !target_active && !target_led) else $error("target while disabled");
   tgt_self_a: assert property (target_mode == `TARGET_SELF_RST && $stable(target_mode)
      && !flags.operate && !$past(flags.operate) |-> !target_active) else $error("self target held");
   tgt_latch_a: assert property (target_mode == `TARGET_LATCHED && $stable(target_mode)
      && $past(target_active) && !target_reset && !$past(target_reset) |-> target_active)
      else $error("latched target lost");
   ev_off_a: assert property (!events_enable && !$past(events_enable) |-> events == '0)
      else $error("event while disabled");
   pkp_ev_a: assert property (events_enable && $rose(flags.pickup) |=> events.pickup_event)
      else $error("no pickup event");
   dpo_ev_a: assert property (events_enable && $fell(flags.pickup) |=> events.dropout_event)
      else $error("no dropout event");
   op_ev_a: assert property (events_enable && $rose(flags.operate) |=> events.operate_event)
      else $error("no operate event");
   cover property ($rose(flags.operate));
   cover property (flags.dropout);
   cover property (target_active && !flags.operate);
endmodule
bind protection_element protection_element_checker CHK (.clk, .rstn, .function_enable,
   .target_mode, .events_enable, .block_in, .run_extra, .target_reset, .programmed_store,
   .programmed_value, .flags, .events, .target_active, .target_led, .trouble_led,
   .in_service_led, .contacts_enable);

// ===== verif/protection_element_output_logic_test.sv
// Self-checking bench for the protection element
`timescale 1ns/100ps
`include "element_defs.svh"
module protection_element_output_logic_test;
   import element_pkg::*;
   // ---------------------------------------------------------------
   // Signals, design and helpers
   // ---------------------------------------------------------------
   logic        clk, rstn, function_enable, grouped_class, digital_variant, events_enable;
   logic [1:0]  target_mode;
   logic [2:0]  active_group;
   setting_type settings [`GROUP_COUNT];
   logic        ct2_present, digital_in, block_in, run_extra, target_reset;
   logic        programmed_store, programmed_value;
   logic [15:0] ct2_scale;
   meas_type    meas_ct1, meas_ct2;
   flags_type   flags;
   events_type  events;
   logic        target_active, target_led, trouble_led, in_service_led, contacts_enable;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          n;
   protection_element DUT (.clk, .rstn, .function_enable, .grouped_class, .digital_variant,
      .target_mode, .events_enable, .active_group, .settings, .ct2_present, .ct2_scale,
      .meas_ct1, .meas_ct2, .digital_in, .block_in, .run_extra, .target_reset,
      .programmed_store, .programmed_value, .flags, .events, .target_active, .target_led,
      .trouble_led, .in_service_led, .contacts_enable);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic wait_flag(input bit op, input logic v, output int c);
      c = 0;
      do begin
         tick(1);
         c++;
      end while ((op ? flags.operate : flags.pickup) !== v && c < 300);
      chk(c < 300, 1, "flag wait");
   endtask
   task automatic put(input meas_type m);
      @(posedge clk);
      meas_ct1 <= m;
   endtask
   task automatic grp(input int g, input meas_type lo, input delay_type d, input delay_type r);
      @(posedge clk);
      settings[g] <= '{lo, lo + 16'h0080, d, r};
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {rstn, function_enable, digital_variant, events_enable, ct2_present} = '0;
      {digital_in, block_in, target_reset, programmed_store, programmed_value} = '0;
      {grouped_class, run_extra, target_mode, active_group} = {2'b11, `TARGET_DISABLED, 3'h1};
      {ct2_scale, meas_ct1, meas_ct2} = '0;
      for (int i = 0; i < `GROUP_COUNT; i++) settings[i] = '{16'hFF00, 16'hFFF0, 24'h0, 24'h0};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      tick(1);
      chk({trouble_led, in_service_led, contacts_enable}, 3'b100, "not programmed");
      chk(flags, 3'b000, "flags idle");
      @(posedge clk);
      {programmed_store, programmed_value} <= 2'b11;
      @(posedge clk);
      programmed_store <= 1'b0;
      tick(2);
      chk({trouble_led, in_service_led}, 2'b01, "programmed");
      $display("test status done");
      grp(0, 16'h0100, 24'h000005, 24'h000004);
      {function_enable, events_enable, target_mode} <= {2'b11, `TARGET_SELF_RST};
      tick(3);
      put(16'h0150);
      wait_flag(0, 1, n);
      put(16'h0000);
      wait_flag(0, 0, n);
      put(16'h0150);
      wait_flag(0, 1, n);
      wait_flag(1, 1, n);
      chk(n, 6, "pickup delay");
      chk({contacts_enable, target_led, target_active}, 3'b111, "operate outputs");
      put(16'h0000);
      wait_flag(0, 0, n);
      chk(flags, 3'b011, "dropout in operate");
      wait_flag(1, 0, n);
      chk(n, 4, "reset delay");
      tick(1);
      chk(target_active, 0, "self reset");
      $display("test timing done");
      for (int g = 0; g < 6; g++) grp(g, meas_type'(16'h0100 * (g + 1)), 24'h0, 24'h0);
      put(16'h0240);
      for (int g = 1; g <= 6; g++) begin
         @(posedge clk);
         active_group <= 3'(g);
         tick(4);
         chk(flags.pickup, g == 2, "group select");
      end
      @(posedge clk) {grouped_class, active_group} <= {1'b0, 3'h2};
      tick(4);
      chk(flags.pickup, 0, "control class");
      @(posedge clk);
      {grouped_class, active_group, ct2_present, ct2_scale} <= {1'b1, 3'h1, 1'b1, 16'h0080};
      {meas_ct1, meas_ct2} <= {16'h0090, 16'h0120};
      tick(4);
      chk(flags.pickup, 1, "scaled sum");
      @(posedge clk) ct2_present <= 1'b0;
      tick(4);
      chk(flags.pickup, 0, "single input");
      $display("test settings done");
      @(posedge clk) {digital_variant, digital_in, events_enable} <= 3'b110;
      tick(5);
      chk(flags.pickup, 1, "digital high");
      @(posedge clk) digital_in <= 1'b0;
      tick(5);
      chk(flags.pickup, 0, "digital low");
      @(posedge clk) {digital_variant, meas_ct1} <= {1'b0, 16'h0120};
      tick(4);
      @(posedge clk) block_in <= 1'b1;
      tick(4);
      chk(flags, 3'b000, "blocked");
      @(posedge clk) block_in <= 1'b0;
      tick(5);
      chk(flags.pickup, 1, "unblocked");
      @(posedge clk) run_extra <= 1'b0;
      tick(2);
      chk(flags, 3'b000, "run low");
      @(posedge clk) run_extra <= 1'b1;
      tick(3);
      @(posedge clk) function_enable <= 1'b0;
      tick(2);
      chk(flags, 3'b000, "disabled");
      $display("test supervision done");
      @(posedge clk) {function_enable, events_enable, target_mode} <= {2'b11, `TARGET_LATCHED};
      tick(5);
      put(16'h0000);
      tick(6);
      chk({flags.operate, target_active, target_led}, 3'b011, "latched");
      @(posedge clk) target_reset <= 1'b1;
      @(posedge clk) target_reset <= 1'b0;
      tick(3);
      chk(target_active, 0, "latch cleared");
      @(posedge clk) target_mode <= `TARGET_DISABLED;
      put(16'h0120);
      tick(6);
      chk({flags.operate, target_active, target_led}, 3'b100, "no target");
      $display("test targets done");
      conclude();
   end
endmodule
